// file: common/out_cfg_pkg.sv
// shared constants for the serial output configuration slave and its master
// assumes both ends are clocked by one sys_clk domain of their own
package out_cfg_pkg;
	localparam logic [3:0] addr_prefix     = 4'hd;
	localparam logic [7:0] reg_style       = 8'h10;
	localparam logic [7:0] reg_swing_lo    = 8'h11;
	localparam logic [7:0] reg_swing_hi    = 8'h12;
	localparam logic [7:0] reg_enable      = 8'h13;
	localparam logic [7:0] reg_i2c_addr    = 8'h0e;
	localparam logic [7:0] reg_last        = 8'h1f;
	localparam logic [7:0] style_reset     = 8'h00;
	localparam logic [7:0] swing_reset     = 8'h00;
	localparam logic [1:0] swing_750_500   = 2'h0;
	localparam logic [1:0] swing_500_pecl  = 2'h1;
	localparam logic [1:0] swing_350_lvds  = 2'h2;
	localparam logic [1:0] swing_reserved  = 2'h3;
	localparam int         sys_clk_khz     = 20000;
	localparam int         scl_std_khz     = 100;
	localparam int         scl_fast_khz    = 400;
	localparam int         div_std         = sys_clk_khz / (4 * scl_std_khz);
	localparam int         div_fast        = sys_clk_khz / (4 * scl_fast_khz);
	localparam logic [1:0] cmd_write       = 2'h1;
	localparam logic [1:0] cmd_read        = 2'h2;
	localparam logic [7:0] sreg_ctrl       = 8'h00;
	localparam logic [7:0] sreg_dev_addr   = 8'h01;
	localparam logic [7:0] sreg_reg_addr   = 8'h02;
	localparam logic [7:0] sreg_data       = 8'h03;
	localparam logic [7:0] sreg_status     = 8'h04;
endpackage

// file: common/two_wire_if.sv
// two-wire serial bus between configuration master and output configuration slave
// open-drain wire levels are resolved here from each side's enable
`timescale 1ns/1ps
interface two_wire_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic scl_oe_s;
	logic sda_oe_s;
	logic scl;
	logic sda;
	assign scl = ~(scl_oe_m | scl_oe_s);
	assign sda = ~(sda_oe_m | sda_oe_s);
	modport master (input scl, input sda, output scl_oe_m, output sda_oe_m);
	modport slave  (input scl, input sda, output scl_oe_s, output sda_oe_s);
endinterface

// file: verilog/serial_output_config_slave.sv
// output configuration slave: style, swing and enable bits behind a two-wire port
// assumes scl and sda are asynchronous to sys_clk; srst stands in for power-up
`timescale 1ns/1ps
// Functional notes
// - per-output style bit, 0 pecl, reset 0
// - two-bit swing code per output, reset 00
// - swing codes 10 and 11 stored as written
// - master avoids 750mV swing at 1.8V supply
// - enable bit 0 tristates pair, 1 drives
// - power-up loads all enables from pin
// - slave address prefix 1101 plus straps
// - low address bits follow the straps
// - standard and fast mode clock rates
// - register-address byte first, repeated start reads
// - pointer increments after each byte, msb first
// - transfer may stop after any byte
// - written byte commits at its ack
// - 0x20-0xff writes ignored, reads zero
module serial_output_config_slave (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// straps
	input  wire logic       power_on_enable_pin,
	input  wire logic       addr_strap_hi,
	input  wire logic       addr_strap_mid,
	input  wire logic       addr_strap_lo,
	// link
	two_wire_if.slave       bus,
	// output configuration
	output logic [7:0]      output_signal_style,
	output logic [15:0]     output_swing_level,
	output logic [7:0]      output_drive_enable,
	output logic [7:0]      output_true_leg_oe,
	output logic [7:0]      output_complement_leg_oe
);
	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_addr  = 3'h1,
		st_ack   = 3'h2,
		st_rx    = 3'h3,
		st_tx    = 3'h4,
		st_mack  = 3'h5
	} phase_e;

	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_q;
	logic       sda_q;
	logic [2:0] strap_sync0;
	logic [2:0] strap_sync1;
	logic       pod_sync0;
	logic       pod_sync1;
	logic       preset_done;
	phase_e     phase;
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	logic       is_read;
	logic       have_ptr;
	logic [7:0] ptr;
	logic       ack_drive;
	logic       ack_pending;
	logic       acked;
	logic [6:0] own_addr;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic [7:0] rd_byte;

	always_ff @(posedge sys_clk) begin
		scl_sync <= {scl_sync[0], bus.scl};
		sda_sync <= {sda_sync[0], bus.sda};
		scl_q    <= scl_sync[1];
		sda_q    <= sda_sync[1];
		strap_sync0 <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
		strap_sync1 <= strap_sync0;
		pod_sync0   <= power_on_enable_pin;
		pod_sync1   <= pod_sync0;
	end

	assign scl_rise   = scl_sync[1] & ~scl_q;
	assign scl_fall   = ~scl_sync[1] & scl_q;
	assign start_seen = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
	assign stop_seen  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
	assign own_addr   = {out_cfg_pkg::addr_prefix, strap_sync1};

	always_comb begin
		rd_byte = 8'h00;
		case (ptr)
			out_cfg_pkg::reg_style:    rd_byte = output_signal_style;
			out_cfg_pkg::reg_swing_lo: rd_byte = output_swing_level[7:0];
			out_cfg_pkg::reg_swing_hi: rd_byte = output_swing_level[15:8];
			out_cfg_pkg::reg_enable:   rd_byte = output_drive_enable;
			out_cfg_pkg::reg_i2c_addr: rd_byte = {1'b0, own_addr};
			default:                   rd_byte = 8'h00;
		endcase
	end

	// protocol engine; the sync delay is far below a 400 kHz half period
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase       <= st_idle;
			shift       <= 8'h00;
			bit_cnt     <= 4'h0;
			is_read     <= 1'b0;
			have_ptr    <= 1'b0;
			ptr         <= 8'h00;
			ack_drive   <= 1'b0;
			ack_pending <= 1'b0;
			acked       <= 1'b0;
		end else if (stop_seen) begin
			phase     <= st_idle;
			ack_drive <= 1'b0;
			have_ptr  <= 1'b0;
		end else if (start_seen) begin
			phase      <= st_addr;
			bit_cnt    <= 4'h0;
			ack_drive  <= 1'b0;
		end else begin
			case (phase)
				st_idle: begin
					ack_drive <= 1'b0;
				end
				st_addr, st_rx: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], sda_sync[1]};
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (phase == st_addr) begin
							if (shift[7:1] == own_addr) begin
								is_read   <= shift[0];
								ack_drive <= 1'b1;
								phase     <= st_ack;
								ack_pending <= 1'b0;
							end else begin
								phase <= st_idle;
							end
						end else begin
							ack_drive   <= 1'b1;
							ack_pending <= 1'b1;
							phase       <= st_ack;
						end
					end
				end
				st_ack: begin
					if (scl_fall) begin
						ack_drive <= 1'b0;
						if (ack_pending) begin
							if (!have_ptr) begin
								ptr      <= shift;
								have_ptr <= 1'b1;
							end else begin
								ptr <= ptr + 8'h01;
							end
							phase <= st_rx;
						end else if (is_read) begin
							shift     <= rd_byte;
							ack_drive <= ~rd_byte[7];
							phase     <= st_tx;
						end else begin
							phase <= st_rx;
						end
						ack_pending <= 1'b0;
					end
				end
				st_tx: begin
					if (scl_fall) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							ack_drive <= 1'b0;
							phase     <= st_mack;
							bit_cnt   <= 4'h0;
							ptr       <= ptr + 8'h01;
						end else begin
							shift     <= {shift[6:0], 1'b0};
							ack_drive <= ~shift[6];
						end
					end
				end
				st_mack: begin
					if (scl_rise) begin
						acked <= ~sda_sync[1];
					end
					if (scl_fall) begin
						if (acked) begin
							shift     <= rd_byte;
							ack_drive <= ~rd_byte[7];
							phase     <= st_tx;
						end else begin
							phase <= st_idle;
						end
					end
				end
				default: phase <= st_idle;
			endcase
		end
	end

	// a byte lands at its ack so an early stop keeps everything already sent
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			output_signal_style <= out_cfg_pkg::style_reset;
			output_swing_level  <= {out_cfg_pkg::swing_reset, out_cfg_pkg::swing_reset};
			output_drive_enable <= 8'h00;
			preset_done         <= 1'b0;
		end else begin
			if (!preset_done) begin
				output_drive_enable <= {8{pod_sync1}};
				preset_done         <= 1'b1;
			end
			if (phase == st_ack && ack_pending && have_ptr && scl_fall) begin
				// the pointer steps on at this same edge, so the byte lands at its old value
				case (ptr)
					out_cfg_pkg::reg_style:    output_signal_style      <= shift;
					out_cfg_pkg::reg_swing_lo: output_swing_level[7:0]  <= shift;
					out_cfg_pkg::reg_swing_hi: output_swing_level[15:8] <= shift;
					out_cfg_pkg::reg_enable:   output_drive_enable      <= shift;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus.sda_oe_s             <= 1'b0;
			bus.scl_oe_s             <= 1'b0;
			output_true_leg_oe       <= 8'h00;
			output_complement_leg_oe <= 8'h00;
		end else begin
			bus.sda_oe_s             <= ack_drive;
			bus.scl_oe_s             <= 1'b0;
			output_true_leg_oe       <= output_drive_enable;
			output_complement_leg_oe <= output_drive_enable;
		end
	end
endmodule

// file: verilog/serial_config_master.sv
// two-wire bus master that writes or reads one byte of the configuration slave
// assumes software on sys_clk drives the plain register port
`timescale 1ns/1ps
module serial_config_master (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// software port
	input  wire logic [7:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_write,
	input  wire logic       sw_read,
	output logic [7:0]      sw_rdata,
	// link
	two_wire_if.master      bus
);
	typedef enum logic [2:0] {
		ms_idle  = 3'h0,
		ms_start = 3'h1,
		ms_byte  = 3'h2,
		ms_rstart= 3'h3,
		ms_stop  = 3'h4
	} mstate_e;

	logic [1:0]  ctrl;
	logic        fast;
	logic [6:0]  dev_addr;
	logic [7:0]  reg_addr;
	logic [7:0]  data;
	logic [7:0]  rx;
	logic        nack;
	mstate_e     st;
	logic [1:0]  quarter;
	logic [7:0]  tick;
	logic [3:0]  bitn;
	logic [1:0]  byte_idx;
	logic [8:0]  tx;
	logic [1:0]  sda_s;
	logic        busy;

	always_ff @(posedge sys_clk) sda_s <= {sda_s[0], bus.sda};

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fast <= 1'b0;
			dev_addr <= {out_cfg_pkg::addr_prefix, 3'h0};
			reg_addr <= 8'h00;
			data <= 8'h00;
			sw_rdata <= 8'h00;
		end else begin
			if (sw_write && sw_addr == out_cfg_pkg::sreg_ctrl) fast <= sw_wdata[2];
			if (sw_write && sw_addr == out_cfg_pkg::sreg_dev_addr) dev_addr <= sw_wdata[6:0];
			if (sw_write && sw_addr == out_cfg_pkg::sreg_reg_addr) reg_addr <= sw_wdata;
			if (sw_write && sw_addr == out_cfg_pkg::sreg_data) data <= sw_wdata;
			if (sw_read) begin
				case (sw_addr)
					out_cfg_pkg::sreg_ctrl:     sw_rdata <= {5'h00, fast, 2'h0};
					out_cfg_pkg::sreg_dev_addr: sw_rdata <= {1'b0, dev_addr};
					out_cfg_pkg::sreg_reg_addr: sw_rdata <= reg_addr;
					out_cfg_pkg::sreg_data:     sw_rdata <= rx;
					out_cfg_pkg::sreg_status:   sw_rdata <= {6'h00, nack, busy};
					default:                    sw_rdata <= 8'h00;
				endcase
			end
		end
	end

	assign busy = (st != ms_idle);

	// quarter-period ticker sets 100 or about 417 kHz
	always_ff @(posedge sys_clk) begin
		if (srst || st == ms_idle) begin
			tick <= 8'h00;
			quarter <= 2'h0;
		end else if (tick == (fast ? 8'(out_cfg_pkg::div_fast - 1) : 8'(out_cfg_pkg::div_std - 1))) begin
			tick <= 8'h00;
			quarter <= quarter + 2'h1;
		end else begin
			tick <= tick + 8'h01;
		end
	end

	// byte sequence: address+w, register, then data or restart address+r
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= ms_idle;
			ctrl <= 2'h0;
			bus.scl_oe_m <= 1'b0;
			bus.sda_oe_m <= 1'b0;
			bitn <= 4'h0;
			byte_idx <= 2'h0;
			tx <= 9'h000;
			rx <= 8'h00;
			nack <= 1'b0;
		end else begin
			case (st)
				ms_idle: begin
					if (sw_write && sw_addr == out_cfg_pkg::sreg_ctrl && sw_wdata[1:0] != 2'h0) begin
						ctrl <= sw_wdata[1:0];
						nack <= 1'b0;
						byte_idx <= 2'h0;
						st <= ms_start;
					end
				end
				ms_start, ms_rstart: begin
					if (tick == 8'h00) begin
						case (quarter)
							2'h0: begin bus.sda_oe_m <= 1'b0; bus.scl_oe_m <= 1'b0; end
							2'h1: bus.sda_oe_m <= 1'b1;
							2'h2: bus.scl_oe_m <= 1'b1;
							default: begin
								tx <= {dev_addr, st == ms_rstart, 1'b1};
								bitn <= 4'h0;
								st <= ms_byte;
							end
						endcase
					end
				end
				ms_byte: begin
					if (tick == 8'h00) begin
						case (quarter)
							2'h0: bus.sda_oe_m <= ~tx[8];
							2'h1: bus.scl_oe_m <= 1'b0;
							2'h2: begin
								// the read data byte's ack slot carries our own nack, not the slave's answer
								if (bitn == 4'h8 && byte_idx != 2'h3) nack <= nack | sda_s[1];
								else if (bitn != 4'h8 && byte_idx == 2'h3) rx <= {rx[6:0], sda_s[1]};
							end
							default: begin
								bus.scl_oe_m <= 1'b1;
								tx <= {tx[7:0], 1'b1};
								bitn <= bitn + 4'h1;
								// ack slot released; a single-byte read thereby ends in a nack
								if (bitn == 4'h7) tx <= 9'h1ff;
								if (bitn == 4'h8) begin
									bitn <= 4'h0;
									byte_idx <= byte_idx + 2'h1;
									if (byte_idx == 2'h0) tx <= {reg_addr, 1'b1};
									else if (byte_idx == 2'h1 && ctrl == out_cfg_pkg::cmd_write) tx <= {data, 1'b1};
									else if (byte_idx == 2'h1) st <= ms_rstart;
									else if (byte_idx == 2'h2 && ctrl == out_cfg_pkg::cmd_read) tx <= 9'h1ff;
									else st <= ms_stop;
								end
							end
						endcase
					end
				end
				ms_stop: begin
					if (tick == 8'h00) begin
						case (quarter)
							2'h0: bus.sda_oe_m <= 1'b1;
							2'h1: bus.scl_oe_m <= 1'b0;
							2'h2: bus.sda_oe_m <= 1'b0;
							default: st <= ms_idle;
						endcase
					end
				end
				default: st <= ms_idle;
			endcase
		end
	end
endmodule

// file: verification/link_assertions.sv
// checker on the two-wire link between the configuration master and the slave
// assumes sys_clk samples the resolved wire levels of two_wire_if
`timescale 1ns/1ps
module link_assertions (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// link
	input wire logic scl_oe_m,
	input wire logic sda_oe_m,
	input wire logic scl_oe_s,
	input wire logic sda_oe_s,
	input wire logic scl,
	input wire logic sda
);
	// loose bound: a repeated start may shorten one period below the divider's figure
	localparam int min_period = 30;
	logic       scl_q;
	logic       sda_q;
	logic [3:0] rises;
	logic [7:0] since_rise;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	always_ff @(posedge sys_clk) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// saturates at 15 so an idle bus never looks like an address byte
	always_ff @(posedge sys_clk) begin
		if (srst)
			rises <= 4'hf;
		else if (scl && scl_q && sda_q && !sda)
			rises <= 4'h0;
		else if (scl && !scl_q && rises != 4'hf)
			rises <= rises + 4'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (srst)
			since_rise <= 8'hff;
		else if (scl && !scl_q)
			since_rise <= 8'h00;
		else if (since_rise != 8'hff)
			since_rise <= since_rise + 8'h01;
	end
	property p_no_stretch; !scl_oe_s; endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("slave held the clock line");
	property p_min_period; scl && !scl_q |-> since_rise >= min_period; endproperty
	a_min_period: assert property (p_min_period) else $error("clock period too short");
	property p_idle_reset; $fell(srst) |-> !scl_oe_m && !sda_oe_m && !sda_oe_s; endproperty
	a_idle_reset: assert property (p_idle_reset) else $error("link not released after reset");
	property p_addr_quiet; rises < 4'h8 |-> !sda_oe_s; endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove data during address byte");
	property p_sda_change; $changed(sda_oe_s) |-> !scl && !scl_q; endproperty
	a_sda_change: assert property (p_sda_change) else $error("slave changed data while clock high");
	property p_ack_late; $rose(sda_oe_s) |-> !$past(scl, 2) && $past(scl, 8); endproperty
	a_ack_late: assert property (p_ack_late) else $error("slave drive not tied to clock fall");
	property p_ack_hold; $rose(sda_oe_s) |-> sda_oe_s [*8]; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("slave drive too short");
	property p_no_frame; scl && scl_q && sda != sda_q |-> !sda_oe_s && !$past(sda_oe_s); endproperty
	a_no_frame: assert property (p_no_frame) else $error("slave made a start or stop");
	c_ack: cover property ($rose(sda_oe_s));
	c_master_bit: cover property (sda_oe_m && scl);
	c_stop: cover property (scl && scl_q && !sda_q && sda);
endmodule

// file: verification/serial_output_config_slave_test.sv
// bench: master and slave joined over two_wire_if, driven through the software port
// assumes a 50 ns sys_clk; the link clock comes from the master's divider
`timescale 1ns/1ps
module serial_output_config_slave_test;
	logic        sys_clk = 1'h0;
	logic        srst = 1'h1;
	logic        pod = 1'h1;
	logic [2:0]  strap = 3'h5;
	logic [7:0]  sw_addr = 8'h00;
	logic [7:0]  sw_wdata = 8'h00;
	logic        sw_write = 1'h0;
	logic        sw_read = 1'h0;
	logic [7:0]  sw_rdata;
	logic [7:0]  style;
	logic [15:0] swing;
	logic [7:0]  enable;
	logic [7:0]  t_oe;
	logic [7:0]  c_oe;
	logic [7:0]  rd;
	logic [7:0]  stat;
	logic [7:0]  first_byte = 8'h00;
	logic [6:0]  dev_ok;
	int          nbits = 0;
	int          err_total = 0;
	int          cmp_count = 0;
	assign dev_ok = {out_cfg_pkg::addr_prefix, strap};
	two_wire_if bus ();
	serial_output_config_slave u_serial_output_config_slave (.sys_clk, .srst, .power_on_enable_pin(pod),
		.addr_strap_hi(strap[2]), .addr_strap_mid(strap[1]), .addr_strap_lo(strap[0]), .bus,
		.output_signal_style(style), .output_swing_level(swing), .output_drive_enable(enable),
		.output_true_leg_oe(t_oe), .output_complement_leg_oe(c_oe));
	serial_config_master u_serial_config_master (.sys_clk, .srst, .sw_addr, .sw_wdata, .sw_write,
		.sw_read, .sw_rdata, .bus);
	link_assertions u_link_assertions (.sys_clk, .srst, .scl_oe_m(bus.scl_oe_m), .sda_oe_m(bus.sda_oe_m),
		.scl_oe_s(bus.scl_oe_s), .sda_oe_s(bus.sda_oe_s), .scl(bus.scl), .sda(bus.sda));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// first byte after the latest start or repeated start, as seen on the wire
	always @(negedge bus.sda) begin
		if (bus.scl === 1'h1)
			nbits = 0;
	end
	always @(posedge bus.scl) begin
		if (nbits < 8)
			first_byte = {first_byte[6:0], bus.sda};
		nbits++;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_write <= 1'h1;
		@(posedge sys_clk);
		sw_write <= 1'h0;
	endtask
	task automatic sw_rd(input logic [7:0] a);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_read <= 1'h1;
		@(posedge sys_clk);
		sw_read <= 1'h0;
		#1 rd = sw_rdata;
	endtask
	// one byte per command; rd holds the data register afterwards
	task automatic xfer(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
		input logic is_rd, input logic fast);
		int n;
		sw_wr(out_cfg_pkg::sreg_reg_addr, ra);
		sw_wr(out_cfg_pkg::sreg_data, d);
		sw_wr(out_cfg_pkg::sreg_dev_addr, {1'h0, dev});
		sw_wr(out_cfg_pkg::sreg_ctrl, {5'h0, fast, is_rd ? out_cfg_pkg::cmd_read : out_cfg_pkg::cmd_write});
		repeat (4) @(posedge sys_clk);
		for (n = 0; n < 6000; n++) begin
			sw_rd(out_cfg_pkg::sreg_status);
			if (rd[0] === 1'h0)
				break;
		end
		stat = rd;
		if (n == 6000) begin
			$display("CHECK FAILED t=%0t transfer hung", $time);
			err_total++;
			print_verdict();
		end
		sw_rd(out_cfg_pkg::sreg_data);
	endtask
	task automatic do_reset(input logic p);
		@(posedge sys_clk);
		srst <= 1'h1;
		pod  <= p;
		repeat (4) @(posedge sys_clk);
		srst <= 1'h0;
		repeat (12) @(posedge sys_clk);
	endtask
	task automatic t_reset();
		do_reset(1'h1);
		check({style, swing}, 24'h0);
		check({enable, t_oe, c_oe}, 24'hffffff);
		do_reset(1'h0);
		check({enable, t_oe, c_oe}, 24'h0);
	endtask
	task automatic t_regs();
		logic [7:0] ra [4] = '{8'h13, 8'h12, 8'h11, 8'h10};
		// swing words use all four codes, 00 included, so the bench stands for a supply above 1.8V
		logic [7:0] dv [4] = '{8'h5a, 8'h1b, 8'he4, 8'ha5};
		for (int i = 0; i < 4; i++) begin
			xfer(dev_ok, ra[i], dv[i], 1'h0, 1'h1);
			check(stat[1], 1'h0);
			check({bus.scl, bus.sda}, 2'h3);
		end
		repeat (2) @(posedge sys_clk);
		check({enable, t_oe, c_oe}, 24'h5a5a5a);
		check({swing, style}, 24'h1be4a5);
		for (int i = 0; i < 4; i++) begin
			xfer(dev_ok, ra[i], 8'h00, 1'h1, i != 0);
			check(rd, dv[i]);
			check(first_byte, {dev_ok, 1'h1});
		end
		xfer(dev_ok, 8'h0e, 8'h00, 1'h1, 1'h1);
		check(rd, {1'h0, dev_ok});
		xfer(dev_ok, 8'h25, 8'hff, 1'h0, 1'h1);
		check(first_byte, {dev_ok, 1'h0});
		check({enable, swing, style}, 32'h5a1be4a5);
		xfer(dev_ok, 8'h25, 8'h00, 1'h1, 1'h1);
		check(rd, 8'h00);
	endtask
	task automatic t_commit();
		int n;
		fork
			xfer(dev_ok, 8'h10, 8'h3c, 1'h0, 1'h0);
			begin
				for (n = 0; n < 20000 && style !== 8'h3c; n++) begin
					@(posedge sys_clk);
					#1;
				end
				check(bus.scl, 1'h0);
			end
		join
		check(style, 8'h3c);
	endtask
	task automatic t_addr();
		xfer({out_cfg_pkg::addr_prefix, 3'h4}, 8'h10, 8'hff, 1'h0, 1'h1);
		check({stat[1], style}, 9'h13c);
		@(posedge sys_clk);
		strap <= 3'h4;
		repeat (4) @(posedge sys_clk);
		xfer({out_cfg_pkg::addr_prefix, 3'h4}, 8'h10, 8'hc3, 1'h0, 1'h1);
		check({stat[1], style}, 9'h0c3);
		xfer(dev_ok, 8'h0e, 8'h00, 1'h1, 1'h1);
		check(rd, {1'h0, out_cfg_pkg::addr_prefix, 3'h4});
	endtask
	initial begin
		t_reset();
		t_regs();
		t_commit();
		t_addr();
		print_verdict();
	end
endmodule
